// ===== hdl/bld_params.svh
`ifndef BLD_PARAMS_SVH
`define BLD_PARAMS_SVH
// ****************************************************************
// Major opcodes.
// ****************************************************************
`define BLD_OP_BRC_REG 6'h27
`define BLD_OP_ORI 6'h28
`define BLD_OP_AND_IMMEDIATE 6'h29
`define BLD_OP_XOR_IMMEDIATE 6'h2A
`define BLD_OP_AND_NOT_IMMEDIATE 6'h2B
`define BLD_OP_IMMP 6'h2C
`define BLD_OP_RET 6'h2D
`define BLD_OP_JMP 6'h2E
`define BLD_OP_BRC_IMM 6'h2F
// ****************************************************************
// Condition codes, jump and return selectors.
// ****************************************************************
`define BLD_CC_EQ 3'h0
`define BLD_CC_NE 3'h1
`define BLD_CC_LT 3'h2
`define BLD_CC_LE 3'h3
`define BLD_CC_GT 3'h4
`define BLD_CC_GE 3'h5
`define BLD_J_REL 5'h10
`define BLD_J_REL_LINK 5'h14
`define BLD_J_ABS 5'h08
`define BLD_J_ABS_D 5'h18
`define BLD_J_ABS_LINK 5'h1C
`define BLD_J_BRK 5'h0C
`define BLD_R_SUB 5'h10
`define BLD_R_INT 5'h11
`define BLD_R_BRK 5'h12
// ****************************************************************
// Status bit positions, reset values and steps.
// ****************************************************************
`define BLD_SW_IE 1
`define BLD_SW_BIP 3
`define BLD_PC_RST 32'h0000_0000
`define BLD_REG_RST 32'h0000_0000
`define BLD_PC_STEP 32'h0000_0004
`endif

// ===== hdl/bld_pkg.sv
// ****************************************************************
// Shared types.
// ****************************************************************
`default_nettype none
package bld_pkg;
  // Execution state: issuing, or waiting on the data memory.
  typedef enum logic {BLD_EXEC, BLD_MEM} bld_state_t;
  // Data memory request bundle.
  typedef struct packed {
    logic valid;
    logic we;
    logic [3:0] be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bld_mem_req_t;
endpackage
`default_nettype wire

// ===== hdl/bld_core.sv
// Function
// (RL1) Thirty-two 32-bit general registers with 5-bit selects, plus two special registers.
// (RL2) Register zero reads zero; writes to it are dropped.
// (RL3) Reset clears every general register.
// (RL4) Register-offset conditional branch tests first source against zero, adds second source.
// (RL5) Condition field top bit selects the delayed form, same test and target.
// (RL6) Immediate conditional branch adds the extended immediate instead.
// (RL7) Relative jump adds immediate; link form saves own address.
// (RL8) Absolute jump loads immediate; link form saves current address.
// (RL9) Software break jumps absolute, saves address, sets break flag.
// (RL10) Returns go to source plus immediate; interrupt return sets enable flag.
// (RL11) Break return goes to source plus immediate, clears break flag.
// (RL12) Immediate OR, AND, XOR and AND-NOT write the destination.
// (RL13) Byte load fills low byte, clears the upper 24 bits.
// (RL14) Halfword load fills low half, clears upper half; word load fills all.
// (RL15) Address is first source plus immediate or plus second source.
// (RL16) Stores write low byte, low half or whole word of the data register.
// (RL17) Immediate prefix supplies the upper half of the next immediate.
// (RL18) Delayed forms run one slot instruction; undelayed taken branches discard it.
// (RL19) Break flag is status bit 28, set by software or hardware break.
// (RL20) Interrupt enable flag is status bit 30.
`timescale 1ns/1ps
`include "bld_params.svh"
`default_nettype none
module bld_core (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Instruction stream.
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  output logic instr_ready,
  output logic [31:0] fetch_addr,
  output logic flush,
  // Data memory.
  output bld_pkg::bld_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Break input, status and register observation.
  input wire logic hw_break,
  output logic [31:0] status_word,
  input wire logic [4:0] peek_sel,
  output logic [31:0] peek_data
);
  import bld_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [31:0] regs_q [32];
  bld_state_t state_q;
  logic [31:0] pc_q;
  logic slot_q;
  logic [31:0] tgt_q;
  logic ie_q;
  logic bip_q;
  logic imm_pend_q;
  logic [15:0] imm_hi_q;
  bld_mem_req_t mem_q;
  logic [4:0] ld_rd_q;
  logic [1:0] ld_size_q;

  // ****************************************************************
  // Field decode and operands.
  // ****************************************************************
  // Bit 0 of the instruction word is its most significant bit.
  logic [5:0] op;
  logic [4:0] f_d;
  logic [4:0] f_a;
  logic [4:0] f_b;
  logic [31:0] a_val;
  logic [31:0] b_val;
  logic [31:0] d_val;
  logic [31:0] imm_x;
  logic take;
  assign op = instr[31:26];
  assign f_d = instr[25:21];
  assign f_a = instr[20:16];
  assign f_b = instr[15:11];
  assign a_val = (f_a == 5'h00) ? 32'h0000_0000 : regs_q[f_a]; // RL2
  assign b_val = (f_b == 5'h00) ? 32'h0000_0000 : regs_q[f_b]; // RL2
  assign d_val = (f_d == 5'h00) ? 32'h0000_0000 : regs_q[f_d]; // RL2
  // A pending prefix replaces the sign extension.
  assign imm_x = imm_pend_q ? {imm_hi_q, instr[15:0]} : {{16{instr[15]}}, instr[15:0]}; // RL17
  assign instr_ready = (state_q == BLD_EXEC);
  assign take = instr_valid && instr_ready;

  // Instruction classes.
  logic is_brc;
  logic is_jmp;
  logic is_ret;
  logic is_log;
  logic is_mem;
  assign is_brc = (op == `BLD_OP_BRC_REG) || (op == `BLD_OP_BRC_IMM);
  assign is_jmp = (op == `BLD_OP_JMP);
  assign is_ret = (op == `BLD_OP_RET);
  assign is_log = ({op[5:2], 2'b00} == `BLD_OP_ORI);
  assign is_mem = (op[5:4] == 2'b11);

  // ****************************************************************
  // Branch condition and targets.
  // ****************************************************************
  logic zero;
  logic neg;
  logic cond;
  assign zero = (a_val == 32'h0000_0000);
  assign neg = a_val[31];
  assign cond = (f_d[2:0] == `BLD_CC_EQ) ? zero : // RL4
    (f_d[2:0] == `BLD_CC_NE) ? !zero :
    (f_d[2:0] == `BLD_CC_LT) ? neg :
    (f_d[2:0] == `BLD_CC_LE) ? (neg || zero) :
    (f_d[2:0] == `BLD_CC_GT) ? !(neg || zero) :
    (f_d[2:0] == `BLD_CC_GE) ? !neg : 1'b0;

  // Jump selector decode.
  logic j_ok;
  logic j_link;
  logic j_brk;
  assign j_ok = (f_a == `BLD_J_REL) || (f_a == `BLD_J_REL_LINK) || (f_a == `BLD_J_ABS)
    || (f_a == `BLD_J_ABS_D) || (f_a == `BLD_J_ABS_LINK) || (f_a == `BLD_J_BRK);
  assign j_link = is_jmp && ((f_a == `BLD_J_REL_LINK) || (f_a == `BLD_J_ABS_LINK)
    || (f_a == `BLD_J_BRK)); // RL7 RL8 RL9
  assign j_brk = is_jmp && (f_a == `BLD_J_BRK);

  // Return selector decode.
  logic r_ok;
  logic r_int;
  logic r_brk;
  assign r_int = is_ret && (f_d == `BLD_R_INT);
  assign r_brk = is_ret && (f_d == `BLD_R_BRK);
  assign r_ok = r_int || r_brk || (is_ret && (f_d == `BLD_R_SUB));

  // Taken decision, delayed flag and destination.
  logic taken;
  logic delayed;
  logic [31:0] target;
  assign taken = (is_brc && cond) || (is_jmp && j_ok) || r_ok;
  assign delayed = is_brc ? f_d[4] : is_jmp ? f_a[4] : 1'b1; // RL5 RL10
  assign target = (op == `BLD_OP_BRC_REG) ? pc_q + b_val : // RL4
    (is_jmp && f_a[3]) ? imm_x : // RL8 RL9
    is_ret ? a_val + imm_x : // RL10 RL11
    pc_q + imm_x; // RL6 RL7
  assign flush = take && !slot_q && taken && !delayed; // RL18

  // ****************************************************************
  // Logical and memory datapath.
  // ****************************************************************
  logic [31:0] log_res;
  assign log_res = (op == `BLD_OP_ORI) ? (a_val | imm_x) : // RL12
    (op == `BLD_OP_AND_IMMEDIATE) ? (a_val & imm_x) :
    (op == `BLD_OP_XOR_IMMEDIATE) ? (a_val ^ imm_x) : (a_val & ~imm_x);

  // Address uses the immediate when the form bit is set.
  logic [31:0] ea;
  logic [3:0] st_be;
  logic [31:0] st_data;
  assign ea = a_val + (op[3] ? imm_x : b_val); // RL15
  // Byte lane 0 is the most significant byte of the bus.
  assign st_be = (op[1:0] == 2'b00) ? (4'h8 >> ea[1:0]) : // RL16
    (op[1:0] == 2'b01) ? (ea[1] ? 4'h3 : 4'hC) : 4'hF;
  assign st_data = (op[1:0] == 2'b00) ? {4{d_val[7:0]}} : // RL16
    (op[1:0] == 2'b01) ? {2{d_val[15:0]}} : d_val;

  // Load formatting by size and lane.
  logic [31:0] ld_sh;
  logic [31:0] ld_val;
  logic ld_done;
  assign ld_sh = mem_rdata >> {~mem_q.addr[1:0], 3'b000};
  assign ld_val = (ld_size_q == 2'b00) ? {24'h00_0000, ld_sh[7:0]} : // RL13
    (ld_size_q == 2'b01) ? {16'h0000, mem_q.addr[1] ? mem_rdata[15:0]
    : mem_rdata[31:16]} : mem_rdata; // RL14
  assign ld_done = (state_q == BLD_MEM) && mem_ack && !mem_q.we;

  // ****************************************************************
  // Register write port.
  // ****************************************************************
  logic rf_we;
  logic [4:0] rf_wa;
  logic [31:0] rf_wd;
  assign rf_we = ld_done || (take && (is_log || j_link));
  assign rf_wa = ld_done ? ld_rd_q : f_d;
  assign rf_wd = ld_done ? ld_val : is_log ? log_res : pc_q; // RL7 RL8 RL9

  // General registers; slot zero never stores.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= `BLD_REG_RST; // RL3
      end
    end else if (rf_we && (rf_wa != 5'h00)) begin // RL2
      regs_q[rf_wa] <= rf_wd; // RL1
    end
  end

  // ****************************************************************
  // Program counter, delay slot and prefix.
  // ****************************************************************
  logic [31:0] pc_d;
  logic slot_d;
  assign pc_d = !take ? pc_q : slot_q ? tgt_q : // RL18
    (taken && !delayed) ? target : pc_q + `BLD_PC_STEP;
  assign slot_d = take ? (!slot_q && taken && delayed) : slot_q;

  // Control flow registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_q <= `BLD_PC_RST;
      slot_q <= 1'b0;
      tgt_q <= `BLD_PC_RST;
      imm_pend_q <= 1'b0;
      imm_hi_q <= 16'h0000;
    end else begin
      pc_q <= pc_d;
      slot_q <= slot_d;
      if (take) begin
        tgt_q <= target;
        imm_pend_q <= (op == `BLD_OP_IMMP); // RL17
        imm_hi_q <= instr[15:0];
      end
    end
  end

  // ****************************************************************
  // Status flags.
  // ****************************************************************
  logic ie_d;
  logic bip_d;
  assign ie_d = (take && !slot_q && r_int) ? 1'b1 : ie_q; // RL10
  // A break arriving with a break return wins over the clear.
  assign bip_d = (hw_break || (take && !slot_q && j_brk)) ? 1'b1 : // RL9 RL19
    (take && !slot_q && r_brk) ? 1'b0 : bip_q; // RL11

  // Flag registers and status image.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ie_q <= 1'b0;
      bip_q <= 1'b0;
    end else begin
      ie_q <= ie_d;
      bip_q <= bip_d;
    end
  end
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`BLD_SW_IE] = ie_q; // RL20
    status_word[`BLD_SW_BIP] = bip_q; // RL19
  end

  // ****************************************************************
  // Memory access sequencing.
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= BLD_EXEC;
      mem_q <= '0;
      ld_rd_q <= 5'h00;
      ld_size_q <= 2'b00;
    end else begin
      case (state_q)
        BLD_EXEC: begin
          if (take && is_mem) begin
            state_q <= BLD_MEM;
            mem_q <= '{valid: 1'b1, we: op[2], be: st_be, addr: ea, wdata: st_data};
            ld_rd_q <= f_d;
            ld_size_q <= op[1:0];
          end
        end
        BLD_MEM: begin
          if (mem_ack) begin
            state_q <= BLD_EXEC;
            mem_q.valid <= 1'b0;
          end
        end
        default: state_q <= BLD_EXEC;
      endcase
    end
  end

  // Outputs.
  assign mem_req = mem_q;
  assign fetch_addr = pc_q;
  assign peek_data = (peek_sel == 5'h00) ? 32'h0000_0000 : regs_q[peek_sel];

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_zero_read: assert property (peek_sel == 5'h00 |-> peek_data == 32'h0) // RL2
    else $error("Register zero read nonzero.");
  // The storage behind register zero must never take a write either.
  chk_zero_kept: assert property (regs_q[0] == 32'h0000_0000) // RL2
    else $error("Register zero storage was written.");
  chk_brk_sets: assert property (take && !slot_q && j_brk |=> status_word[3]) // RL9
    else $error("Break did not set flag.");
  chk_rtb_clears: assert property (take && !slot_q && r_brk && !hw_break
    |=> !status_word[3]) // RL11
    else $error("Break return did not clear flag.");
  chk_rti_sets: assert property (take && !slot_q && r_int |=> status_word[1]) // RL10
    else $error("Interrupt return did not set enable.");
  chk_slot_runs: assert property (take && !slot_q && taken && delayed
    |=> fetch_addr == $past(fetch_addr) + 32'h4 ##0 slot_q) // RL18
    else $error("Delay slot skipped.");
  chk_flush_tgt: assert property (flush |=> fetch_addr == $past(target)) // RL4
    else $error("Undelayed branch went astray.");
  chk_mem_addr: assert property (take && is_mem
    |=> mem_req.valid && mem_req.addr == $past(ea) && !instr_ready) // RL15
    else $error("Memory request wrong.");
  chk_byte_load: assert property (ld_done && ld_size_q == 2'b00 && ld_rd_q != 5'h00
    |=> regs_q[$past(ld_rd_q)][31:8] == 24'h00_0000) // RL13
    else $error("Byte load upper bits set.");
  chk_link_addr: assert property (take && j_link |-> rf_we && rf_wd == fetch_addr) // RL7
    else $error("Link value wrong.");
  cov_delayed: cover property (take && taken && delayed ##1 take);
  cov_load: cover property (ld_done);
  cov_prefix: cover property (take && op == `BLD_OP_IMMP ##1 take);
endmodule // bld_core
`default_nettype wire

// ===== testbench/bld_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bld_core_tb;
  import bld_pkg::*;
  // ****************************************************************
  // Ports, model state and counters.
  // ****************************************************************
  typedef struct packed {
    logic [1:0] kind;
    logic fl;
    logic [4:0] sel;
    logic [3:0] be;
    logic [31:0] pc, val, st, addr, wd;
  } bld_note_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic [31:0] instr = 32'h0000_0000;
  logic instr_ready, flush;
  logic [31:0] fetch_addr, status_word, peek_data, mem_rdata;
  bld_mem_req_t mem_req;
  logic mem_ack = 1'b0;
  logic hw_break = 1'b0;
  logic [4:0] peek_sel = 5'h00;
  logic [31:0] rdat = 32'h0000_0000;
  logic [31:0] m [32];
  logic [31:0] pc, st, tgt;
  logic [15:0] pre;
  logic pre_v, slot;
  bld_note_t q [$];
  integer seed = 94701;
  integer mismatches = 0;
  integer samples_checked = 0;
  integer wait_n = 0;
  bld_core bld_core_inst (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .fetch_addr(fetch_addr), .flush(flush), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .hw_break(hw_break),
    .status_word(status_word), .peek_sel(peek_sel), .peek_data(peek_data));
  // The clock toggles every half period.
  always #2.5 clk = ~clk;
  // Data memory answers after zero to two extra cycles; idle data is inverted.
  assign mem_rdata = mem_ack ? rdat : ~rdat;
  always @(posedge clk) begin
    #1;
    if (mem_ack) begin
      mem_ack = 1'b0;
    end else if (mem_req.valid === 1'b1) begin
      if (wait_n == 0) begin
        mem_ack = 1'b1;
        wait_n = $unsigned($random(seed)) % 3;
      end else begin
        wait_n = wait_n - 1;
      end
    end
  end
  // ****************************************************************
  // Helpers.
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [15:0] r16();
    return 16'($random(seed));
  endfunction
  function automatic logic [31:0] ins(input logic [5:0] o, input logic [4:0] d, a,
      input logic [15:0] i);
    return {o, d, a, i};
  endfunction
  function automatic logic cond(input logic [2:0] c, input logic [31:0] x);
    case (c)
      3'h0: return x == 0;
      3'h1: return x != 0;
      3'h2: return x[31];
      3'h3: return x[31] || x == 0;
      3'h4: return !x[31] && x != 0;
      3'h5: return !x[31];
      default: return 1'b0;
    endcase
  endfunction
  task automatic wr(input logic [4:0] r, input logic [31:0] v);
    if (r != 0) m[r] = v;
  endtask
  // Models one instruction, notes its results, then presents it until taken.
  task automatic run(input logic [31:0] w, input logic hb);
    logic [5:0] op;
    logic [4:0] rd, ra;
    logic [31:0] a, imm, npc, t, ad, v;
    logic tk, dl;
    bld_note_t n, mn;
    integer i;
    if (instr_ready !== 1'b1) instr_valid = 1'b0;
    for (i = 0; i < 40 && instr_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    op = w[31:26];
    rd = w[25:21];
    ra = w[20:16];
    a = m[ra];
    imm = pre_v ? {pre, w[15:0]} : {{16{w[15]}}, w[15:0]};
    pre_v = 1'b0;
    npc = pc + 32'h0000_0004;
    {tk, dl, t} = '0;
    mn = '0;
    case (op)
      6'h28: wr(rd, a | imm);
      6'h29: wr(rd, a & imm);
      6'h2A: wr(rd, a ^ imm);
      6'h2B: wr(rd, a & ~imm);
      6'h2C: {pre_v, pre} = {1'b1, w[15:0]};
      6'h27, 6'h2F: begin
        tk = cond(w[23:21], a);
        dl = w[25];
        t = pc + (op[3] ? imm : m[w[15:11]]);
      end
      6'h2D: begin
        tk = rd inside {5'h10, 5'h11, 5'h12};
        dl = 1'b1;
        t = a + imm;
        if (rd == 5'h11) st[1] = 1'b1;
        if (rd == 5'h12) st[3] = 1'b0;
      end
      6'h2E: begin
        tk = ra inside {5'h10, 5'h14, 5'h08, 5'h18, 5'h1C, 5'h0C};
        dl = ra[4];
        t = ra[3] ? imm : pc + imm;
        if (ra[2]) wr(rd, pc);
        if (ra == 5'h0C) st[3] = 1'b1;
      end
      default: if (op[5:4] == 2'b11) begin
        rdat = $random(seed);
        ad = a + (op[3] ? imm : m[w[15:11]]);
        v = rdat >> (op[1] ? 0 : op[0] ? 8 * (2 - ad[1:0]) : 8 * (3 - ad[1:0]));
        mn.val = op[1] ? v : op[0] ? {16'h0000, v[15:0]} : {24'h00_0000, v[7:0]};
        mn.be = op[1] ? 4'hF : op[0] ? (ad[1] ? 4'h3 : 4'hC) : 4'h8 >> ad[1:0];
        mn.wd = op[1] ? m[rd] : op[0] ? {2{m[rd][15:0]}} : {4{m[rd][7:0]}};
        {mn.kind, mn.addr, mn.sel} = {op[2] ? 2'h2 : 2'h1, ad, rd};
      end
    endcase
    if (hb) st[3] = 1'b1;
    if (tk && !dl) npc = t;
    if (slot) npc = tgt;
    n = '0;
    {n.fl, n.sel, n.pc, n.val, n.st} = {tk && !dl && !slot, rd, npc, m[rd], st};
    q.push_back(n);
    slot = tk && dl && !slot;
    tgt = t;
    pc = npc;
    if (mn.kind == 2'h1) wr(rd, mn.val);
    if (mn.kind != 2'h0) mn.val = m[rd];
    if (mn.kind != 2'h0) q.push_back(mn);
    {instr, instr_valid, hw_break} = {w, 1'b1, hb};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (instr_ready !== 1'b1 && i < 50);
    #1;
  endtask
  // Takes the oldest note at each completion and compares the outputs.
  always @(posedge clk) begin : mon
    bld_note_t n;
    bld_mem_req_t r;
    logic fs, tk, ak, rdy;
    tk = instr_valid === 1'b1 && instr_ready === 1'b1;
    ak = mem_ack && mem_req.valid === 1'b1;
    {r, fs, rdy} = {mem_req, flush, instr_ready};
    if ((tk || ak) && q.size() > 0) begin
      n = q.pop_front();
      #1;
      peek_sel = n.sel;
      #1;
      if (n.kind != 2'h0) check(r.addr, n.addr, "address");
      if (n.kind != 2'h0) check({31'h0, r.we}, {31'h0, n.kind[1]}, "write");
      if (n.kind != 2'h0) check({31'h0, rdy}, 32'h0000_0000, "ready");
      if (n.kind == 2'h2) check({28'h0, r.be}, {28'h0, n.be}, "lanes");
      if (n.kind == 2'h2) check(r.wdata, n.wd, "store data");
      if (n.kind != 2'h2) check(peek_data, n.val, "register");
      if (n.kind == 2'h0) check(fetch_addr, n.pc, "pc");
      if (n.kind == 2'h0) check(status_word, n.st, "status");
      if (n.kind == 2'h0) check({31'h0, fs}, {31'h0, n.fl}, "flush");
    end
  end
  // Cuts a hang short.
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin : main
    integer i, k;
    logic [4:0] js [6];
    logic [2:0] mo [6];
    js = '{5'h10, 5'h14, 5'h08, 5'h18, 5'h1C, 5'h0C};
    mo = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    for (i = 0; i < 32; i++) m[i] = 32'h0000_0000;
    {pc, st, tgt, pre, pre_v, slot} = '0;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    for (i = 0; i < 32; i++) begin
      peek_sel = 5'(i);
      #1 check(peek_data, 32'h0000_0000, "reset register");
      @(posedge clk);
      #1;
    end
    check(fetch_addr, 32'h0000_0000, "reset pc");
    check(status_word, 32'h0000_0000, "reset status");
    $display("test reset done");
    for (k = 0; k < 60; k++) begin
      if (k % 3 == 0) run(ins(6'h2C, 5'h00, 5'h00, r16()), 1'b0);
      run(ins(k < 20 ? 6'h28 : 6'(6'h28 + k % 4), 5'(k % 11), 5'(k % 7), r16()), 1'b0);
    end
    $display("test logic done");
    for (k = 0; k < 48; k++) begin
      run(ins(k / 12 % 2 ? 6'h2F : 6'h27, {1'(k / 6 % 2), 1'b0, 3'(k % 6)}, 5'(k % 4),
        k / 12 % 2 ? r16() : 16'h2000), 1'b0);
      if (k / 6 % 2) run(ins(6'h28, 5'h05, 5'h05, r16()), 1'b0);
    end
    $display("test branch done");
    for (k = 0; k < 6; k++) begin
      run(ins(6'h2E, 5'h07, js[k], r16()), 1'b0);
      if (js[k][4]) run(ins(6'h28, 5'h08, 5'h08, r16()), 1'b0);
    end
    run(ins(6'h28, 5'h00, 5'h00, 16'h0000), 1'b1);
    for (k = 0; k < 5; k++) begin
      run(ins(6'h2D, k > 1 ? 5'h12 : 5'(5'h10 + k), 5'h03, r16()), k == 3);
      run(ins(6'h28, 5'h08, 5'h00, r16()), 1'b0);
    end
    $display("test jump done");
    for (k = 0; k < 36; k++) begin
      run(ins(6'h2C, 5'h00, 5'h00, r16()), 1'b0);
      run(ins(6'h28, 5'h09, 5'h00, r16() & 16'hFFFC), 1'b0);
      i = mo[k / 2 % 6][1] ? 0 : mo[k / 2 % 6][0] ? r16() & 2 : r16() & 3;
      run(ins(6'h28, 5'h0A, 5'h00, 16'(i)), 1'b0);
      run(ins({2'b11, 1'(k % 2), mo[k / 2 % 6]}, 5'(k % 8), 5'h09,
        k % 2 ? 16'(i) : 16'h5000), 1'b0);
    end
    $display("test memory done");
    instr_valid = 1'b0;
    repeat (8) @(posedge clk);
    check(q.size(), 32'h0000_0000, "pending notes");
    final_report();
  end
endmodule // bld_core_tb
`default_nettype wire
